// >>> pkg/sdls_pkg.sv
// shared constants for the dead band loop switch
package sdls_pkg;

   // ==========================================================
   // clock and settle tick timing
   localparam int SDLS_CLK_MHZ  = 100;                      // system clock rate
   localparam int SDLS_TICK_US  = 120;                      // settle tick length
   localparam int SDLS_TICK_CYC = SDLS_TICK_US * SDLS_CLK_MHZ; // cycles per tick

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] SDLS_OFS_MODE   = 8'h00;  // moving-allow bit
   localparam logic [7:0] SDLS_OFS_THRESH = 8'h04;  // exit and entry thresholds
   localparam logic [7:0] SDLS_OFS_DELAY  = 8'h08;  // settle delay in ticks
   localparam logic [7:0] SDLS_OFS_TORQUE = 8'h0C;  // holding and moving torque
   localparam logic [7:0] SDLS_OFS_STATUS = 8'h10;  // loop state, read only

   // ==========================================================
   // field positions
   localparam int SDLS_LO_POS = 0;                  // low half of a word
   localparam int SDLS_HI_POS = 16;                 // high half of a word
   localparam int SDLS_ST_OPEN_POS = 0;             // status: open loop
   localparam int SDLS_ST_QUAL_POS = 1;             // status: entry qualified
   localparam int SDLS_ST_DBND_POS = 2;             // status: plain dead band

   // ==========================================================
   // values after reset
   localparam logic        SDLS_RST_MODE    = 1'b0;     // only when stopped
   localparam logic [15:0] SDLS_RST_EXIT    = 16'h000A; // exit threshold
   localparam logic [15:0] SDLS_RST_ENTRY   = 16'h0004; // entry threshold
   localparam logic [15:0] SDLS_RST_DELAY   = 16'h04E2; // 1250 ticks
   localparam logic [15:0] SDLS_RST_HOLD_TQ = 16'h0000; // holding torque
   localparam logic [15:0] SDLS_RST_MOVE_TQ = 16'h0000; // moving torque

   // ==========================================================
   // loop states
   typedef enum logic [0:0] {
      SDLS_CLOSED = 1'b0,
      SDLS_OPEN   = 1'b1
   } sdls_state_t;

endpackage : sdls_pkg

// >>> hdl/sdls_settle_timer.sv
// settle delay counter driven by a 120 us tick divider
`timescale 1ns/10ps
`default_nettype none

module sdls_settle_timer
   import sdls_pkg::*;
#(
   parameter int TICK_CYC = SDLS_TICK_CYC              // cycles per tick
) (
   input  wire logic        clk,                       // system clock
   input  wire logic        rst,                       // sync reset, high
   input  wire logic        qualify,                   // entry conditions hold
   input  wire logic [15:0] delay,                     // ticks to wait
   output logic             done                       // delay has elapsed
);

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

   logic [15:0] pre_r;                                 // tick divider
   logic [15:0] ticks_r;                               // ticks while qualified
   wire         tick_en  = (pre_r == TICK_LAST);       // one-cycle tick pulse
   wire         ticks_sat = (ticks_r == 16'hFFFF);

   // ==========================================================
   // divider and tick counter, both restart when qualify drops
   always_ff @(posedge clk) begin
      if (rst || !qualify) begin
         pre_r   <= 16'h0000;
         ticks_r <= 16'h0000;
      end else begin
         pre_r <= tick_en ? 16'h0000 : pre_r + 16'h0001;
         if (tick_en && !ticks_sat) begin
            ticks_r <= ticks_r + 16'h0001;
         end
      end
   end

   // elapsed once the full count of ticks has passed
   assign done = qualify && (ticks_r >= delay);

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_settle_restart: assert property (!qualify |=> ticks_r == 16'h0000)
      else $error("settle count not restarted");
   a_tick_spacing: assert property ($rose(ticks_r[0]) |-> $past(tick_en))
      else $error("tick counted without divider pulse");

endmodule : sdls_settle_timer

`default_nettype wire

// >>> hdl/sdls_loop_switch.sv
// dead band loop switch with its register slave
`timescale 1ns/10ps
`default_nettype none

module sdls_loop_switch
   import sdls_pkg::*;
#(
   parameter int TICK_CYC = SDLS_TICK_CYC              // cycles per settle tick
) (
   input  wire logic        CLK_SYS,                   // 100 MHz clock
   input  wire logic        SYS_RST,                   // sync reset, high
   input  wire logic [15:0] POS_ERR,                   // signed error, counts
   input  wire logic [15:0] TORQUE_CMD,                // signed present torque
   input  wire logic        MOTION_ACTIVE,             // profiler is moving
   output logic             OPEN_LOOP,                 // holding open loop
   output logic             DEAD_BAND,                 // plain dead band active
   input  wire logic [7:0]  AV_ADDRESS,                // byte address
   input  wire logic        AV_READ,                   // read request
   input  wire logic        AV_WRITE,                  // write request
   input  wire logic [31:0] AV_WRITEDATA,              // write data
   input  wire logic [3:0]  AV_BYTEENABLE,             // write lanes
   output logic [31:0]      AV_READDATA,               // read data
   output logic             AV_WAITREQUEST             // stall, high
);

   // ==========================================================
   // functions
   function automatic logic [15:0] sdls_abs(input logic [15:0] v);
      sdls_abs = v[15] ? 16'(~v + 16'h0001) : v;
   endfunction : sdls_abs

   function automatic logic [15:0] sdls_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  be);
      sdls_merge = {be[1] ? new_v[15:8] : old_v[15:8],
                    be[0] ? new_v[7:0]  : old_v[7:0]};
   endfunction : sdls_merge

   // ==========================================================
   // configuration registers
   logic        mode_r;                                // moving allowed
   logic [15:0] exit_thr_r;                            // open to closed limit
   logic [15:0] entry_thr_r;                           // closed to open limit
   logic [15:0] delay_r;                               // settle ticks
   logic [15:0] hold_tq_r;                             // holding torque limit
   logic [15:0] move_tq_r;                             // moving torque limit

   sdls_state_t state_r;                               // loop state
   sdls_state_t state_nxt;
   logic        dband_r;                               // dead band flag
   logic        wait_r;                                // bus stall flag
   logic [31:0] rdata_r;                               // read data holder
   logic [31:0] rdata_nxt;

   // ==========================================================
   // error and torque comparisons
   wire [15:0] err_mag   = sdls_abs(POS_ERR);
   wire [15:0] tq_mag    = sdls_abs(TORQUE_CMD);
   wire [15:0] entry_mag = sdls_abs(entry_thr_r);
   wire        entry_neg = entry_thr_r[15];
   wire        lims_zero = (hold_tq_r == 16'h0000) && (move_tq_r == 16'h0000);
   wire        err_out   = err_mag > exit_thr_r;
   wire        err_in    = err_mag <= entry_mag;
   // torque gate skipped for negative entry or plain dead band
   wire        tq_ok     = entry_neg || lims_zero
                           || (tq_mag < hold_tq_r);
   wire        motion_blk = !mode_r && MOTION_ACTIVE;
   wire        qualify   = (state_r == SDLS_CLOSED) && err_in && tq_ok && !motion_blk;
   wire        settle_done;

   // ==========================================================
   // settle delay counter
   sdls_settle_timer #(
      .TICK_CYC (TICK_CYC)
   ) u_settle (
      .clk     (CLK_SYS),
      .rst     (SYS_RST),
      .qualify (qualify),
      .delay   (delay_r),
      .done    (settle_done)
   );

   // ==========================================================
   // loop state decision
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SDLS_CLOSED: begin
            if (qualify && settle_done) begin
               state_nxt = SDLS_OPEN;
            end
         end
         SDLS_OPEN: begin
            if (err_out || motion_blk) begin
               state_nxt = SDLS_CLOSED;
            end
         end
         default: state_nxt = SDLS_CLOSED;
      endcase
   end

   // state and output flags
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         state_r <= SDLS_CLOSED;
         dband_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         dband_r <= (state_nxt == SDLS_OPEN) && lims_zero;
      end
   end

   assign OPEN_LOOP = state_r;
   assign DEAD_BAND = dband_r;

   // ==========================================================
   // bus decode
   wire        req     = AV_READ || AV_WRITE;
   wire        commit  = req && !wait_r;               // master samples low here
   wire        wr_go   = commit && AV_WRITE;
   wire        hit_mode   = (AV_ADDRESS == SDLS_OFS_MODE);
   wire        hit_thresh = (AV_ADDRESS == SDLS_OFS_THRESH);
   wire        hit_delay  = (AV_ADDRESS == SDLS_OFS_DELAY);
   wire        hit_torque = (AV_ADDRESS == SDLS_OFS_TORQUE);
   wire        hit_status = (AV_ADDRESS == SDLS_OFS_STATUS);
   wire [15:0] wd_lo   = AV_WRITEDATA[SDLS_LO_POS +: 16];
   wire [15:0] wd_hi   = AV_WRITEDATA[SDLS_HI_POS +: 16];
   wire [1:0]  be_lo   = AV_BYTEENABLE[1:0];
   wire [1:0]  be_hi   = AV_BYTEENABLE[3:2];

   // read mux, unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_mode) begin
         rdata_nxt[0] = mode_r;
      end else if (hit_thresh) begin
         rdata_nxt = {entry_thr_r, exit_thr_r};
      end else if (hit_delay) begin
         rdata_nxt[15:0] = delay_r;
      end else if (hit_torque) begin
         rdata_nxt = {move_tq_r, hold_tq_r};
      end else if (hit_status) begin
         rdata_nxt[SDLS_ST_OPEN_POS] = (state_r == SDLS_OPEN);
         rdata_nxt[SDLS_ST_QUAL_POS] = qualify;
         rdata_nxt[SDLS_ST_DBND_POS] = dband_r;
      end
   end

   // one stall cycle per access, then a single low cycle
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         wait_r <= !(req && wait_r);
         if (req && wait_r) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign AV_READDATA    = rdata_r;
   assign AV_WAITREQUEST = wait_r;

   // ==========================================================
   // register writes, taken only at the committing edge
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         mode_r      <= SDLS_RST_MODE;
         exit_thr_r  <= SDLS_RST_EXIT;
         entry_thr_r <= SDLS_RST_ENTRY;
         delay_r     <= SDLS_RST_DELAY;
         hold_tq_r   <= SDLS_RST_HOLD_TQ;
         move_tq_r   <= SDLS_RST_MOVE_TQ;
      end else if (wr_go) begin
         if (hit_mode && be_lo[0]) begin
            mode_r <= AV_WRITEDATA[0];
         end
         if (hit_thresh) begin
            exit_thr_r  <= sdls_merge(exit_thr_r, wd_lo, be_lo);
            entry_thr_r <= sdls_merge(entry_thr_r, wd_hi, be_hi);
         end
         if (hit_delay) begin
            delay_r <= sdls_merge(delay_r, wd_lo, be_lo);
         end
         if (hit_torque) begin
            hold_tq_r <= sdls_merge(hold_tq_r, wd_lo, be_lo);
            move_tq_r <= sdls_merge(move_tq_r, wd_hi, be_hi);
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   sequence s_opened;
      $rose(state_r == SDLS_OPEN);
   endsequence

   sequence s_gate_met;
      (state_r == SDLS_CLOSED) && err_in && !motion_blk;
   endsequence

   a_exit_on_error: assert property (
      (state_r == SDLS_OPEN) && err_out |=> state_r == SDLS_CLOSED)
      else $error("open loop kept past exit threshold");

   a_entry_error_gate: assert property (
      s_opened |-> $past(err_mag) <= $past(entry_mag))
      else $error("opened with error outside entry limit");

   a_entry_torque: assert property (
      s_opened and $past(!entry_neg && !lims_zero) |-> $past(tq_mag) < $past(hold_tq_r))
      else $error("opened with torque above holding limit");

   a_negative_skip: assert property (
      s_gate_met and entry_neg |-> qualify)
      else $error("negative entry still tested torque");

   a_settle_wait: assert property (
      s_opened |-> $past(settle_done) && $past(qualify))
      else $error("opened before settle delay");

   a_motion_close: assert property (
      !mode_r && MOTION_ACTIVE |=> state_r == SDLS_CLOSED)
      else $error("mode 0 stayed open during motion");

   a_moving_hold: assert property (
      mode_r && (state_r == SDLS_OPEN) && !err_out |=> state_r == SDLS_OPEN)
      else $error("mode 1 left open loop within limits");

   a_deadband_zero: assert property (
      s_gate_met and lims_zero |-> qualify ##1 (dband_r == (state_r == SDLS_OPEN)))
      else $error("zero torque limits not plain dead band");

   a_bus_answer: assert property (
      req && wait_r && !$past(req && !wait_r) |=> !wait_r ##1 wait_r)
      else $error("bus answer not single cycle");

   // ==========================================================
   // checks on settle restart, closing and the register side
   sequence s_lapse_back;
      !qualify ##1 (qualify && (delay_r != 16'h0000));
   endsequence

   sequence s_closed;
      $fell(state_r == SDLS_OPEN);
   endsequence

   a_restart_done: assert property (
      s_lapse_back |-> !settle_done)
      else $error("settle done right after a lapse");

   a_close_reason: assert property (
      s_closed and $past(mode_r) |-> $past(err_out))
      else $error("mode 1 closed without error beyond exit");

   a_open_no_motion: assert property (
      s_opened and $past(!mode_r) |-> !$past(MOTION_ACTIVE))
      else $error("mode 0 opened during motion");

   a_dband_only_open: assert property (
      dband_r |-> state_r == SDLS_OPEN)
      else $error("dead band flag outside open loop");

   a_dband_needs_zero: assert property (
      dband_r |-> $past(lims_zero))
      else $error("dead band flag with torque limits set");

   a_torque_block: assert property (
      s_gate_met and (!entry_neg && !lims_zero && (tq_mag >= hold_tq_r)) |-> !qualify)
      else $error("entry qualified with torque too high");

   a_exit_within: assert property (
      (state_r == SDLS_OPEN) && !err_out && !motion_blk |=> state_r == SDLS_OPEN)
      else $error("open loop left within exit threshold");

   a_entry_range: assert property (
      (state_r == SDLS_CLOSED) && !err_in |=> state_r == SDLS_CLOSED)
      else $error("open loop entered outside entry limit");

   a_delay_write: assert property (
      wr_go && hit_delay && (AV_BYTEENABLE[1:0] == 2'h3) |=> delay_r == $past(wd_lo))
      else $error("settle delay write lost");

   a_mode_write: assert property (
      !wr_go |=> $stable(mode_r))
      else $error("mode bit changed without a write");

   a_read_stands: assert property (
      !(req && wait_r) |=> $stable(rdata_r))
      else $error("read data changed between accesses");

endmodule : sdls_loop_switch

`default_nettype wire

// >>> dv/sdls_drive_model.sv
// partner model: position loop and drive stage feeding the switch
`timescale 1ns/10ps
`default_nettype none

module sdls_drive_model (
   input  wire logic        clk,            // system clock
   input  wire logic        rst,            // sync reset, high
   input  wire logic [15:0] set_err,        // wanted error
   input  wire logic [15:0] set_tq,         // wanted torque
   input  wire logic        set_mot,        // wanted motion flag
   output logic      [15:0] pos_err,        // error to the switch
   output logic      [15:0] torque_cmd,     // torque to the switch
   output logic             motion_active   // profiler moving
);
   // ======================================================
   // loop outputs update once a clock, like a sampled servo loop
   always_ff @(posedge clk) begin
      if (rst) begin
         pos_err       <= 16'h7FFF;  // far off target after reset
         torque_cmd    <= 16'h0000;
         motion_active <= 1'b0;
      end else begin
         pos_err       <= set_err;
         torque_cmd    <= set_tq;
         motion_active <= set_mot;
      end
   end
endmodule : sdls_drive_model
`default_nettype wire

// >>> dv/tb_servo_deadband_loop_switch.sv
// self-checking bench for the dead band loop switch
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_mismatch++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end

module tb_servo_deadband_loop_switch;
   import sdls_pkg::*;
   localparam int TC = 4;                    // short settle tick
   logic        clk, rst, av_rd, av_wr, mot, set_mot, open_l, dband, wait_l;
   logic [15:0] err, tq, set_err, set_tq;
   logic [7:0]  av_a;
   logic [31:0] av_wd, av_rdd;
   logic [3:0]  av_be;
   logic [31:0] exp_q[$];
   int          n_mismatch = 0;
   int          cmp_count = 0;

   sdls_drive_model pm (.clk(clk), .rst(rst), .set_err(set_err), .set_tq(set_tq),
      .set_mot(set_mot), .pos_err(err), .torque_cmd(tq), .motion_active(mot));
   sdls_loop_switch #(.TICK_CYC(TC)) uut (.CLK_SYS(clk), .SYS_RST(rst), .POS_ERR(err),
      .TORQUE_CMD(tq), .MOTION_ACTIVE(mot), .OPEN_LOOP(open_l), .DEAD_BAND(dband),
      .AV_ADDRESS(av_a), .AV_READ(av_rd), .AV_WRITE(av_wr), .AV_WRITEDATA(av_wd),
      .AV_BYTEENABLE(av_be), .AV_READDATA(av_rdd), .AV_WAITREQUEST(wait_l));

   // ======================================================
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // read monitor: oldest note against data taken at the answer edge
   always @(posedge clk) begin
      if (av_rd === 1'b1 && wait_l === 1'b0 && exp_q.size() > 0) begin
         `CHK("readdata", exp_q[0], av_rdd)
         void'(exp_q.pop_front());
      end
   end

   // ======================================================
   // tasks
   task automatic summarize();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge clk);
      av_rd <= !w;
      av_wr <= w;
      av_a  <= a;
      av_wd <= d;
      av_be <= be;
      do @(posedge clk); while (wait_l !== 1'b0);
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask : bus

   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      exp_q.push_back(ex);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
   endtask : rd

   task automatic cfg(input logic m, input logic [15:0] ex, en, dl, ht, mt);
      bus(1'b1, SDLS_OFS_MODE, {31'h0, m}, 4'hF);
      bus(1'b1, SDLS_OFS_THRESH, {en, ex}, 4'hF);
      bus(1'b1, SDLS_OFS_DELAY, {16'h0, dl}, 4'hF);
      bus(1'b1, SDLS_OFS_TORQUE, {mt, ht}, 4'hF);
   endtask : cfg

   task automatic drv(input logic [15:0] e, t, input logic m);
      @(posedge clk);
      set_err <= e;
      set_tq  <= t;
      set_mot <= m;
   endtask : drv

   // cycles until open loop must lie in lo..hi
   task automatic wait_open(input int lo, hi);
      int n;
      n = 0;
      while (open_l !== 1'b1 && n <= hi) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("settle_in_window", 1'b1, (n >= lo && n <= hi && open_l === 1'b1))
   endtask : wait_open

   task automatic hold(input int n, input logic ex);
      repeat (n) @(posedge clk);
      #1;
      `CHK("open_loop", ex, open_l)
   endtask : hold

   function automatic logic [15:0] rnd_err(input int mag);
      logic [15:0] e;
      e = 16'($urandom_range(mag));
      return ($urandom_range(1) != 0) ? -e : e;
   endfunction : rnd_err

   // ======================================================
   // main sequence
   initial begin
      {av_rd, av_wr, set_mot} = 3'b000;
      av_a = 8'h00;
      av_wd = 32'h0;
      av_be = 4'hF;
      set_err = 16'h7FFF;
      set_tq = 16'h0000;
      rst = 1'b1;
      void'($urandom(32'h5fda));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(SDLS_OFS_MODE, 32'h0000_0000);
      rd(SDLS_OFS_THRESH, 32'h0004_000A);
      rd(SDLS_OFS_DELAY, 32'h0000_04E2);
      rd(SDLS_OFS_TORQUE, 32'h0000_0000);
      bus(1'b1, 8'h14, 32'hFFFF_FFFF, 4'hF);
      bus(1'b1, SDLS_OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
      rd(8'h14, 32'h0000_0000);
      rd(SDLS_OFS_STATUS, 32'h0000_0000);
      bus(1'b1, SDLS_OFS_DELAY, 32'hFFFF_FF03, 4'h1);
      rd(SDLS_OFS_DELAY, 32'h0000_0403);
      // entry with torque check, two ticks of settle
      cfg(1'b0, 16'd10, 16'd4, 16'd2, 16'd100, 16'd0);
      drv(rnd_err(4), 16'd50, 1'b0);
      wait_open(2 * TC, 2 * TC + 5);
      rd(SDLS_OFS_STATUS, 32'h0000_0001);
      `CHK("dead_band", 1'b0, dband)
      drv(16'd10, 16'd50, 1'b0);
      hold(4, 1'b1);
      drv(-16'd11, 16'd50, 1'b0);
      hold(3, 1'b0);
      drv(16'd5, 16'd50, 1'b0);
      hold(40, 1'b0);
      drv(16'd3, -16'd100, 1'b0);
      hold(40, 1'b0);
      drv(16'd3, 16'd99, 1'b0);
      wait_open(2 * TC, 2 * TC + 5);
      drv(16'd0, 16'd0, 1'b1);
      hold(3, 1'b0);
      hold(30, 1'b0);
      drv(16'd0, 16'd0, 1'b0);
      wait_open(2 * TC, 2 * TC + 5);
      // moving allowed, negative entry, nonzero settle kept by software
      drv(16'd30, 16'd0, 1'b0);
      cfg(1'b1, 16'd10, 16'hFFFC, 16'd1, 16'd100, 16'd0);
      drv(16'd4, 16'h7FFF, 1'b1);
      wait_open(TC, TC + 5);
      drv(rnd_err(10), 16'h7FFF, 1'b1);
      hold(10, 1'b1);
      drv(16'd11, 16'h7FFF, 1'b1);
      hold(3, 1'b0);
      // both torque limits zero, no settle
      cfg(1'b0, 16'd20, 16'd8, 16'd0, 16'd0, 16'd0);
      drv(-16'd8, 16'd1000, 1'b0);
      wait_open(0, 4);
      `CHK("dead_band", 1'b1, dband)
      rd(SDLS_OFS_STATUS, 32'h0000_0005);
      // reset in mid run: loop closes, registers return to defaults
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      hold(1, 1'b0);
      `CHK("dead_band", 1'b0, dband)
      rd(SDLS_OFS_THRESH, 32'h0004_000A);
      rd(SDLS_OFS_DELAY, 32'h0000_04E2);
      // lapse of entry restarts the count
      drv(16'd30, 16'd0, 1'b0);
      cfg(1'b0, 16'd10, 16'd4, 16'd3, 16'd100, 16'd0);
      drv(16'd2, 16'd0, 1'b0);
      rd(SDLS_OFS_STATUS, 32'h0000_0002);
      hold(4, 1'b0);
      drv(16'd30, 16'd0, 1'b0);
      drv(16'd2, 16'd0, 1'b0);
      wait_open(3 * TC, 3 * TC + 5);
      repeat (3) @(posedge clk);
      summarize();
   end

   // watchdog on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end
endmodule : tb_servo_deadband_loop_switch
`default_nettype wire
